/* src/mcx_exec.sv */
`timescale 1ns/10ps
`default_nettype none
module mcx_exec (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [6:0] upper_pc_latch_i,
  output logic [14:0] pc_o,
  output logic [6:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  output logic file_we_o,
  output logic [7:0] acc_o,
  output logic null_flag_o,
  output logic [14:0] stack_head_o,
  output logic stack_push_o,
  output logic watchdog_timer_clear_o,
  output logic watchdog_expiry_flag_set_o,
  output logic sleep_entry_flag_set_o,
  output logic busy_o
);
  mcx_pkg::mcx_state_t state_q, state_d;
  logic [14:0] pc_q, pc_d;
  logic [7:0] acc_q, acc_d;
  logic null_q, null_d;
  logic [6:0] faddr_q;
  logic [7:0] fwdata_q;
  logic fwe_q;
  logic [14:0] stack_q;
  logic push_q;
  logic wdt_clear_q;
  logic expiry_set_q;
  logic sleep_set_q;
  logic [7:0] result;
  logic write_back;
  logic flush;
  logic exec_now;
  logic is_call, is_clracc, is_kick, is_clear_file_reg, is_invert_file, is_decrement_file, is_dsz;
  logic is_jump;

  // one-hot class of the word now on the fetch bus
  typedef enum logic [8:0] {
    MCX_OP_OTHER = 9'h001,
    MCX_OP_CALL = 9'h002,
    MCX_OP_JUMP = 9'h004,
    MCX_OP_CLRACC = 9'h008,
    MCX_OP_KICK = 9'h010,
    MCX_OP_CLEAR_FILE_REG = 9'h020,
    MCX_OP_INVERT_FILE = 9'h040,
    MCX_OP_DECREMENT_FILE = 9'h080,
    MCX_OP_DSZ = 9'h100
  } mcx_op_t;
  mcx_op_t op;

  function automatic logic is_null(input logic [7:0] v);
    is_null = (v == mcx_pkg::ZERO_BYTE);
  endfunction

  function automatic logic in_exec(input mcx_pkg::mcx_state_t s);
    in_exec = (s == mcx_pkg::MCX_EXEC);
  endfunction

  // unlisted words fall through as plain increments
  function automatic mcx_op_t decode_op(input logic [13:0] w);
    decode_op = MCX_OP_OTHER;
    if (w == mcx_pkg::OP_CALL_VIA_ACC)
      decode_op = MCX_OP_CALL;
    else if (w == mcx_pkg::OP_CLEAR_ACC)
      decode_op = MCX_OP_CLRACC;
    else if (w == mcx_pkg::OP_KICK_WATCHDOG)
      decode_op = MCX_OP_KICK;
    else if (w[13:11] == mcx_pkg::OPC_JUMP_ABS)
      decode_op = MCX_OP_JUMP;
    else if (w[13:7] == mcx_pkg::OPC_CLEAR_FILE)
      decode_op = MCX_OP_CLEAR_FILE_REG;
    else if (w[13:8] == mcx_pkg::OPC_INVERT_FILE)
      decode_op = MCX_OP_INVERT_FILE;
    else if (w[13:8] == mcx_pkg::OPC_DECREMENT_FILE)
      decode_op = MCX_OP_DECREMENT_FILE;
    else if (w[13:8] == mcx_pkg::OPC_DEC_SKIP)
      decode_op = MCX_OP_DSZ;
  endfunction

  assign op = decode_op(instr_i);
  assign exec_now = in_exec(state_q);
  assign is_call = (op == MCX_OP_CALL);
  assign is_clracc = (op == MCX_OP_CLRACC);
  assign is_kick = (op == MCX_OP_KICK);
  assign is_clear_file_reg = (op == MCX_OP_CLEAR_FILE_REG);
  assign is_invert_file = (op == MCX_OP_INVERT_FILE);
  assign is_decrement_file = (op == MCX_OP_DECREMENT_FILE);
  assign is_dsz = (op == MCX_OP_DSZ);
  assign is_jump = (op == MCX_OP_JUMP);

  // decode and execute one instruction per cycle
  always_comb
  begin
    state_d = mcx_pkg::MCX_EXEC;
    pc_d = pc_q + 15'h0001;
    acc_d = acc_q;
    null_d = null_q;
    result = mcx_pkg::ZERO_BYTE;
    write_back = 1'b0;
    flush = 1'b0;
    case (state_q)
      mcx_pkg::MCX_FLUSH:
      begin
        // discarded word runs as a no-op
        // pc still steps over the discarded word
        state_d = mcx_pkg::MCX_EXEC;
      end
      mcx_pkg::MCX_EXEC:
      begin
        if (is_call)
        begin
          pc_d = {upper_pc_latch_i, acc_q};
          // second cycle flushed, no flag change
          flush = 1'b1;
        end
        else if (is_jump)
        begin
          pc_d = {upper_pc_latch_i[6:3], instr_i[mcx_pkg::JUMP_MSB:0]};
          // second cycle flushed, no flag change
          flush = 1'b1;
        end
        else if (is_clracc)
        begin
          acc_d = mcx_pkg::ZERO_BYTE;
          null_d = 1'b1;
        end
        else if (is_clear_file_reg)
        begin
          // zero file register, set null flag
          result = mcx_pkg::ZERO_BYTE;
          write_back = 1'b1;
          null_d = 1'b1;
        end
        else if (is_invert_file || is_decrement_file || is_dsz)
        begin
          if (is_invert_file)
            result = ~file_rdata_i;
          else
            result = file_rdata_i - 8'h01;
          write_back = instr_i[mcx_pkg::DEST_BIT];
          if (!instr_i[mcx_pkg::DEST_BIT])
            acc_d = result;
          // skip form leaves the null flag alone
          if (!is_dsz)
            null_d = is_null(result);
          // skip next word on zero result
          if (is_dsz && is_null(result))
            flush = 1'b1;
        end
        if (flush)
          state_d = mcx_pkg::MCX_FLUSH;
      end
      default:
      begin
        state_d = mcx_pkg::MCX_EXEC;
      end
    endcase
  end

  // flush state holds for one cycle only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= mcx_pkg::MCX_EXEC;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pc_q <= mcx_pkg::PC_RESET;
    else
      pc_q <= pc_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      acc_q <= mcx_pkg::ACC_RESET;
    else
      acc_q <= acc_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      null_q <= 1'b0;
    else
      null_q <= null_d;
  end

  // file register write port
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      faddr_q <= 7'h00;
    else
      faddr_q <= instr_i[mcx_pkg::FILE_MSB:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fwdata_q <= mcx_pkg::ZERO_BYTE;
    else
      fwdata_q <= result;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fwe_q <= 1'b0;
    else
      fwe_q <= exec_now && write_back;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stack_q <= mcx_pkg::PC_RESET;
    else if (exec_now && is_call)
      stack_q <= pc_q + 15'h0001;
  end

  // one-cycle push strobe per call
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      push_q <= 1'b0;
    else
      push_q <= exec_now && is_call;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wdt_clear_q <= 1'b0;
    else
      wdt_clear_q <= exec_now && is_kick;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      expiry_set_q <= 1'b0;
    else
      expiry_set_q <= exec_now && is_kick;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sleep_set_q <= 1'b0;
    else
      sleep_set_q <= exec_now && is_kick;
  end

  assign pc_o = pc_q;
  assign acc_o = acc_q;
  assign null_flag_o = null_q;
  assign file_addr_o = faddr_q;
  assign file_wdata_o = fwdata_q;
  assign file_we_o = fwe_q;
  assign stack_head_o = stack_q;
  assign stack_push_o = push_q;
  assign watchdog_timer_clear_o = wdt_clear_q;
  assign watchdog_expiry_flag_set_o = expiry_set_q;
  assign sleep_entry_flag_set_o = sleep_set_q;
  // busy marks the flushed fetch slot
  assign busy_o = (state_q == mcx_pkg::MCX_FLUSH);
endmodule
`default_nettype wire

/* src/mcx_pkg.sv */
`default_nettype none
package mcx_pkg;
  // opcode encodings (14-bit instruction word)
  localparam logic [13:0] OP_CALL_VIA_ACC = 14'h000A;
  localparam logic [13:0] OP_CLEAR_ACC = 14'h0100;
  localparam logic [13:0] OP_KICK_WATCHDOG = 14'h0064;
  localparam logic [13:0] OP_NOP = 14'h0000;
  // upper opcode fields
  localparam logic [6:0] OPC_CLEAR_FILE = 7'h03;
  localparam logic [5:0] OPC_INVERT_FILE = 6'h09;
  localparam logic [5:0] OPC_DECREMENT_FILE = 6'h03;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
  localparam logic [2:0] OPC_JUMP_ABS = 3'h5;
  // field positions
  localparam int DEST_BIT = 7;
  localparam int FILE_MSB = 6;
  localparam int JUMP_MSB = 10;
  // reset values
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  typedef enum logic [1:0] {
    MCX_EXEC = 2'b01,
    MCX_FLUSH = 2'b10
  } mcx_state_t;
endpackage
`default_nettype wire

/* tb/mcx_exec_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module mcx_exec_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0] acc_o,
  input wire logic null_flag_o,
  input wire logic file_we_o,
  input wire logic stack_push_o,
  input wire logic watchdog_timer_clear_o,
  input wire logic watchdog_expiry_flag_set_o,
  input wire logic sleep_entry_flag_set_o,
  input wire logic [7:0] file_rdata_i,
  input wire logic [6:0] upper_pc_latch_i,
  input wire logic [14:0] pc_o,
  input wire logic [14:0] stack_head_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic call = !busy_o && instr_i == mcx_pkg::OP_CALL_VIA_ACC;
  wire logic jmp = !busy_o && instr_i[13:11] == mcx_pkg::OPC_JUMP_ABS;
  wire logic kick = !busy_o && instr_i == mcx_pkg::OP_KICK_WATCHDOG;
  wire logic dsz = !busy_o && instr_i[13:8] == mcx_pkg::OPC_DEC_SKIP;
  sequence flush_s;
    busy_o ##1 !busy_o;
  endsequence
  a_call_push: assert property (call |=> stack_push_o)
    else $error("no push");
  a_call_two: assert property (call |=> flush_s)
    else $error("no flush");
  a_call_flags: assert property (call |=> $stable(null_flag_o))
    else $error("flag moved");
  a_jump_two: assert property (jmp |=> flush_s)
    else $error("no flush");
  a_jump_flags: assert property (jmp |=> $stable(null_flag_o))
    else $error("flag moved");
  a_clra_zero: assert property (!busy_o &&
    instr_i == mcx_pkg::OP_CLEAR_ACC |=> acc_o == 8'h00 && null_flag_o)
    else $error("bad clear");
  a_kick_clear: assert property (!busy_o &&
    instr_i == mcx_pkg::OP_KICK_WATCHDOG |=> watchdog_timer_clear_o)
    else $error("no kick");
  a_clear_file_reg_write: assert property (!busy_o &&
    instr_i[13:7] == mcx_pkg::OPC_CLEAR_FILE |=> file_we_o && null_flag_o)
    else $error("bad clear");
  a_call_target: assert property (call |=>
    pc_o == {$past(upper_pc_latch_i), $past(acc_o)})
    else $error("bad call target");
  a_call_return: assert property (call |=>
    stack_head_o == $past(pc_o) + 15'h0001)
    else $error("bad return address");
  a_jump_target: assert property (jmp |=>
    pc_o == {$past(upper_pc_latch_i[6:3]), $past(instr_i[10:0])})
    else $error("bad jump target");
  a_kick_flags: assert property (kick |=>
    watchdog_expiry_flag_set_o && sleep_entry_flag_set_o)
    else $error("flags not set");
  a_kick_null: assert property (kick |=> $stable(null_flag_o))
    else $error("flag moved");
  a_skip_taken: assert property (dsz && file_rdata_i == 8'h01 |=>
    flush_s)
    else $error("no skip");
  a_skip_not: assert property (dsz && file_rdata_i != 8'h01 |=>
    !busy_o)
    else $error("bad skip");
endmodule
`default_nettype wire

/* tb/mcx_file_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mcx_file_model (
  input wire logic clk_i,
  input wire logic [6:0] ra_i,
  input wire logic [6:0] wa_i,
  input wire logic [7:0] wd_i,
  input wire logic we_i,
  output logic [7:0] rd_o
);
  logic [7:0] mem_q [128];
  initial
    for (int i = 0; i < 128; i++)
      mem_q[i] = 8'(i);
  always @(posedge clk_i)
    if (we_i)
      mem_q[wa_i] <= wd_i;
  assign rd_o = mem_q[ra_i];
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  num_errors++; $display("BAD %0t mismatch", $time); end end
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [13:0] instr_i = mcx_pkg::OP_NOP;
  logic [6:0] upper_pc_latch_i = 7'h00;
  logic [6:0] file_addr_o;
  logic [7:0] file_rdata_i, file_wdata_o, acc_o, e_acc = 8'h00;
  logic [14:0] pc_o, stack_head_o, e_pc = 15'h0000;
  logic file_we_o, null_flag_o, stack_push_o, busy_o, e_null = 1'b0;
  logic watchdog_timer_clear_o, watchdog_expiry_flag_set_o;
  logic sleep_entry_flag_set_o;
  logic [5:0] fl;
  int num_errors = 0;
  int samples_checked = 0;
  assign fl = {stack_push_o, watchdog_timer_clear_o,
    watchdog_expiry_flag_set_o, sleep_entry_flag_set_o, busy_o, file_we_o};
  always #10 clk_i = ~clk_i;
  mcx_exec dut_u (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
    .file_rdata_i(file_rdata_i), .upper_pc_latch_i(upper_pc_latch_i),
    .pc_o(pc_o), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
    .file_we_o(file_we_o), .acc_o(acc_o), .null_flag_o(null_flag_o),
    .stack_head_o(stack_head_o), .stack_push_o(stack_push_o),
    .watchdog_timer_clear_o(watchdog_timer_clear_o),
    .watchdog_expiry_flag_set_o(watchdog_expiry_flag_set_o),
    .sleep_entry_flag_set_o(sleep_entry_flag_set_o), .busy_o(busy_o));
  mcx_file_model fm_u (.clk_i(clk_i), .ra_i(instr_i[6:0]),
    .wa_i(file_addr_o), .wd_i(file_wdata_o), .we_i(file_we_o),
    .rd_o(file_rdata_i));
  function automatic logic [13:0] enc(int k, logic [10:0] r);
    logic [13:0] t [8];
    t = '{mcx_pkg::OP_CALL_VIA_ACC, mcx_pkg::OP_CLEAR_ACC,
      mcx_pkg::OP_KICK_WATCHDOG, {mcx_pkg::OPC_CLEAR_FILE, r[6:0]},
    {mcx_pkg::OPC_INVERT_FILE, r[7:0]}, {mcx_pkg::OPC_DECREMENT_FILE, r[7:0]},
      {mcx_pkg::OPC_DEC_SKIP, r[7:0]}, {mcx_pkg::OPC_JUMP_ABS, r}};
    return t[k];
  endfunction
  function automatic logic [7:0] alu(int k, logic [7:0] v);
    return k < 4 ? 8'h00 : k == 4 ? ~v : v - 8'h01;
  endfunction
  task automatic step(int k, logic [10:0] r, logic [6:0] lat);
    logic [7:0] v;
    logic [14:0] sh;
    logic [5:0] ef;
    logic wr;
    wr = k == 3 || k > 3 && k < 7 && r[7];
    @(posedge clk_i);
    instr_i <= enc(k, r);
    upper_pc_latch_i <= lat;
    #1;
    v = alu(k, fm_u.mem_q[r[6:0]]);
    sh = e_pc + 15'h0002;
    e_pc = k == 0 ? {lat, e_acc} : k == 7 ? {lat[6:3], r} : sh;
    e_acc = k == 1 || k > 3 && k < 7 && !wr ? v : e_acc;
    e_null = k == 1 || k == 3 || k == 4 || k == 5 ? v == 8'h00 : e_null;
    ef = {k == 0, {3{k == 2}}, k == 0 || k == 7 || k == 6 && v == 8'h00, wr};
    @(posedge clk_i);
    instr_i <= mcx_pkg::OP_NOP;
    #1;
    `CHK(pc_o, e_pc)
    `CHK({acc_o, null_flag_o}, {e_acc, e_null})
    `CHK(fl, ef)
    if (wr)
      `CHK({file_addr_o, file_wdata_o}, {r[6:0], v})
    if (k == 0)
      `CHK(stack_head_o, sh)
  endtask
  task test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(34));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    step(6, 11'h081, 7'h7F);
    step(5, 11'h000, 7'h00);
    step(0, 11'h000, 7'h7F);
    step(7, 11'h7FF, 7'h55);
    repeat (80) step($urandom_range(7), 11'($urandom), 7'($urandom));
    test_done;
  end
  initial
  begin
    #20000;
    num_errors++;
    test_done;
  end
endmodule
bind mcx_exec mcx_exec_properties chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .instr_i(instr_i), .acc_o(acc_o), .null_flag_o(null_flag_o),
  .file_we_o(file_we_o), .stack_push_o(stack_push_o),
  .watchdog_timer_clear_o(watchdog_timer_clear_o),
  .watchdog_expiry_flag_set_o(watchdog_expiry_flag_set_o),
  .sleep_entry_flag_set_o(sleep_entry_flag_set_o),
  .file_rdata_i(file_rdata_i), .upper_pc_latch_i(upper_pc_latch_i),
  .pc_o(pc_o), .stack_head_o(stack_head_o), .busy_o(busy_o));
`default_nettype wire
